// [verilog/pss_pkg.sv]
// constants and types for the phy status summary block
// assumes a 32-bit ahb-lite slave window decoded on haddr[11:0]
package pss_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] SUMMARY_OFS = 12'h010;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h020;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h024;
  localparam logic [11:0] CTRL_OFS = 12'h028;
  //////////////////////////////////////////////////////////////////////
  // summary field positions
  localparam int BIT_RSVD = 15;
  localparam int BIT_XOVER = 14;
  localparam int BIT_RXERR = 13;
  localparam int BIT_POL = 12;
  localparam int BIT_FCAR = 11;
  localparam int BIT_SIGDET = 10;
  localparam int BIT_LOCK = 9;
  localparam int BIT_PAGE = 8;
  localparam int BIT_INTP = 7;
  localparam int BIT_RFAULT = 6;
  localparam int BIT_JAB = 5;
  localparam int BIT_ANEG = 4;
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  //////////////////////////////////////////////////////////////////////
  // interrupt status and mask layout
  localparam int IRQ_W = 5;
  localparam int IRQ_RXERR = 0;
  localparam int IRQ_FCAR = 1;
  localparam int IRQ_RFAULT = 2;
  localparam int IRQ_SIGLOSS = 3;
  localparam int IRQ_LOCKLOSS = 4;
  localparam logic [4:0] IRQ_STAT_RESET = 5'h00;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
  // control: bit 0 qualifies signal detect with descrambler lock
  localparam int CTRL_QUAL_BIT = 0;
  localparam logic CTRL_QUAL_RESET = 1'b0;
  typedef enum {PH_IDLE, PH_READ, PH_WRITE} pss_phase_t;
endpackage : pss_pkg

// [verilog/pss_irq_if.sv]
// interface between the summary core and its interrupt unit
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface pss_irq_if;
  logic [4:0] evt;
  logic wr_status;
  logic wr_mask;
  logic [4:0] wdata;
  logic [4:0] status;
  logic [4:0] mask;
  logic irq;
  modport core (output evt, output wr_status, output wr_mask, output wdata,
                input status, input mask, input irq);
  modport blk (input evt, input wr_status, input wr_mask, input wdata,
               output status, output mask, output irq);
endinterface : pss_irq_if
`default_nettype wire

// [verilog/pss_latch.sv]
// vector of latch-high or latch-low status bits
// assumes clr is a one-cycle pulse from a register read
`timescale 1ns/1ps
`default_nettype none
module pss_latch #(
  parameter int W = 1,
  parameter bit LOW = 1'b0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  // high: event sets, read clears, set wins over clear
  wire [W-1:0] next_high = din | (q & ~clr);
  // low: any drop sticks until a read re-arms to the live level
  wire [W-1:0] next_low = din & (q | clr);
  wire [W-1:0] next_q = LOW ? next_low : next_high;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule : pss_latch
`default_nettype wire

// [verilog/pss_irq.sv]
// sticky interrupt status with write-one-to-clear and a mask
// assumes writes arrive as one-cycle strobes with data
`timescale 1ns/1ps
`default_nettype none
module pss_irq (
  input wire logic core_clk,
  input wire logic nrst,
  pss_irq_if.blk bus
);
  wire [4:0] clr_bits = bus.wr_status ? bus.wdata : 5'h00;
  // a new event in the clearing cycle survives
  wire [4:0] next_status = (bus.status & ~clr_bits) | bus.evt;
  wire [4:0] next_mask = bus.wr_mask ? bus.wdata : bus.mask;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bus.status <= pss_pkg::IRQ_STAT_RESET;
      bus.mask <= pss_pkg::IRQ_MASK_RESET;
    end else begin
      bus.status <= next_status;
      bus.mask <= next_mask;
    end
  end
  assign bus.irq = |(bus.status & bus.mask);
endmodule : pss_irq
`default_nettype wire

// [verilog/pss_summary.sv]
// phy status summary register bank, upper bits, on ahb-lite
// assumes source flags and clear pulses are synchronous to core_clk
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: bit 15 always reads zero; writes to the summary are ignored.
// R2: crossover bit follows force, or live swap when auto enabled.
// R3: receive error latch sets on error, clears on error counter read.
// R4: polarity bit mirrors ten-base status bit 4, not cleared here.
// R5: false carrier latch sets on event, clears on counter read.
// R6: signal detect latches low; optionally qualified by descrambler lock.
// R7: descrambler lock bit latches low until the summary is read.
// R8: page received mirrors expansion flag; summary read never clears it.
// R9: interrupt pending bit reads one while any interrupt is pending.
// R10: remote fault sticks until basic status read or reset.
// R11: jabber mirrors basic status jabber flag, untouched by summary read.
// R12: autoneg complete reads one once negotiation has finished.
// R13: all bits zero after reset; summary read changes no mirrored bit.
module pss_summary (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic crossover_auto_enable,
  input wire logic crossover_force,
  input wire logic crossover_swapped,
  input wire logic rx_error_event,
  input wire logic rx_error_count_rd,
  input wire logic tenbase_polarity_inverted,
  input wire logic false_carrier_event,
  input wire logic false_carrier_count_rd,
  input wire logic signal_detect_raw,
  input wire logic descrambler_lock,
  input wire logic page_received_flag,
  input wire logic interrupt_pending,
  input wire logic remote_fault_event,
  input wire logic basic_mode_status_rd,
  input wire logic jabber_detect_flag,
  input wire logic autoneg_complete,
  output logic irq
);
  //////////////////////////////////////////////////////////////////////
  // address decode helper
  function automatic logic pss_hit(input logic [11:0] a,
                                   input logic [11:0] ofs);
    pss_hit = (a == ofs);
  endfunction : pss_hit

  pss_pkg::pss_phase_t phase;
  logic [11:0] addr_q;
  logic qual_ctrl;
  logic xover_q;
  logic pol_q;
  logic page_q;
  logic intp_q;
  logic jab_q;
  logic aneg_q;
  logic det_prev;
  logic lock_prev;
  logic [2:0] high_q;
  logic [1:0] low_q;
  logic [15:0] summary;

  pss_irq_if irq_bus ();

  //////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire take = hsel & htrans[1] & hready;
  wire [11:0] a_ofs = haddr[11:0];
  wire a_sum = pss_hit(a_ofs, pss_pkg::SUMMARY_OFS);
  wire a_stat = pss_hit(a_ofs, pss_pkg::IRQ_STAT_OFS);
  wire a_mask = pss_hit(a_ofs, pss_pkg::IRQ_MASK_OFS);
  wire a_ctrl = pss_hit(a_ofs, pss_pkg::CTRL_OFS);
  wire sum_rd = take & ~hwrite & a_sum;

  wire wr_now = (phase == pss_pkg::PH_WRITE);
  wire w_stat = wr_now & pss_hit(addr_q, pss_pkg::IRQ_STAT_OFS);
  wire w_mask = wr_now & pss_hit(addr_q, pss_pkg::IRQ_MASK_OFS);
  wire w_ctrl = wr_now & pss_hit(addr_q, pss_pkg::CTRL_OFS);

  wire [31:0] rd_word = a_sum ? {16'h0000, summary} :
                        a_stat ? {27'h0000000, irq_bus.status} :
                        a_mask ? {27'h0000000, irq_bus.mask} :
                        a_ctrl ? {31'h00000000, qual_ctrl} :
                        32'h00000000;

  // read data is sampled at the address edge, so it shows the
  // state of that cycle, not of the data phase
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase <= pss_pkg::PH_IDLE;
      addr_q <= 12'h000;
      hrdata <= 32'h00000000;
    end else begin
      case (phase)
        default: begin
          if (take) begin
            phase <= hwrite ? pss_pkg::PH_WRITE : pss_pkg::PH_READ;
          end else begin
            phase <= pss_pkg::PH_IDLE;
          end
        end
      endcase
      if (take) begin
        addr_q <= a_ofs;
      end
      if (take & ~hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control register; summary offset has no write path [R1]
  wire next_qual = w_ctrl ? hwdata[pss_pkg::CTRL_QUAL_BIT] : qual_ctrl;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      qual_ctrl <= pss_pkg::CTRL_QUAL_RESET;
    end else begin
      qual_ctrl <= next_qual;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // mirrored bits, one cycle behind their sources
  wire next_xover = crossover_force | (crossover_auto_enable & crossover_swapped); // [R2]
  always_ff @(posedge core_clk) begin
    if (!nrst) begin // [R13]
      xover_q <= 1'b0;
      pol_q <= 1'b0;
      page_q <= 1'b0;
      intp_q <= 1'b0;
      jab_q <= 1'b0;
      aneg_q <= 1'b0;
    end else begin
      xover_q <= next_xover; // [R2]
      pol_q <= tenbase_polarity_inverted; // [R4]
      page_q <= page_received_flag; // [R8]
      intp_q <= interrupt_pending; // [R9]
      jab_q <= jabber_detect_flag; // [R11]
      aneg_q <= autoneg_complete; // [R12]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sticky bits
  wire det_qual = qual_ctrl ? (signal_detect_raw & descrambler_lock) : signal_detect_raw; // [R6]

  // [R3] [R5] [R10]
  pss_latch #(.W(3), .LOW(1'b0)) u_high (
    .core_clk(core_clk),
    .nrst(nrst),
    .din({remote_fault_event, false_carrier_event, rx_error_event}),
    .clr({basic_mode_status_rd, false_carrier_count_rd, rx_error_count_rd}),
    .q(high_q)
  );

  // latch-low bits re-arm only on a summary read [R6] [R7]
  pss_latch #(.W(2), .LOW(1'b1)) u_low (
    .core_clk(core_clk),
    .nrst(nrst),
    .din({descrambler_lock, det_qual}),
    .clr({sum_rd, sum_rd}),
    .q(low_q)
  );

  assign summary = {1'b0, xover_q, high_q[0], pol_q, high_q[1], low_q[0],
                    low_q[1], page_q, intp_q, high_q[2], jab_q, aneg_q,
                    4'h0}; // [R1]

  //////////////////////////////////////////////////////////////////////
  // interrupt events
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      det_prev <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      det_prev <= det_qual;
      lock_prev <= descrambler_lock;
    end
  end

  assign irq_bus.evt = {lock_prev & ~descrambler_lock, det_prev & ~det_qual,
                        remote_fault_event, false_carrier_event, rx_error_event};
  assign irq_bus.wr_status = w_stat;
  assign irq_bus.wr_mask = w_mask;
  assign irq_bus.wdata = hwdata[4:0];

  pss_irq u_irq (
    .core_clk(core_clk),
    .nrst(nrst),
    .bus(irq_bus)
  );

  assign irq = irq_bus.irq;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  rsvd_zero_a: assert property ( // [R1]
    sum_rd |=> (hrdata[15] == 1'b0) && (hrdata[3:0] == 4'h0))
    else $error("reserved summary bits read nonzero");

  // mirrors and latches are qualified by nrst: the edge that releases reset
  // still resets the flops, so an attempt started there would see stale inputs
  xover_track_a: assert property ( // [R2]
    nrst |=> summary[14] == ($past(crossover_force) |
                            ($past(crossover_auto_enable) & $past(crossover_swapped))))
    else $error("crossover bit does not follow its settings");

  rxerr_set_a: assert property ( // [R3]
    nrst && rx_error_event |=> summary[13] [*2] or (summary[13] ##1 $past(rx_error_count_rd)))
    else $error("receive error latch not set");

  rxerr_hold_a: assert property ( // [R3]
    summary[13] && !rx_error_count_rd |=> summary[13])
    else $error("receive error latch dropped without counter read");

  rxerr_clr_a: assert property ( // [R3]
    rx_error_count_rd && !rx_error_event |=> !summary[13])
    else $error("receive error latch not cleared by counter read");

  pol_mirror_a: assert property ( // [R4]
    nrst |=> summary[12] == $past(tenbase_polarity_inverted))
    else $error("polarity bit does not mirror its source");

  fcar_latch_a: assert property ( // [R5]
    nrst && false_carrier_event |=> summary[11])
    else $error("false carrier latch not set");

  fcar_hold_a: assert property ( // [R5]
    summary[11] && !false_carrier_count_rd |=> summary[11])
    else $error("false carrier latch dropped without counter read");

  fcar_clr_a: assert property ( // [R5]
    false_carrier_count_rd && !false_carrier_event |=> !summary[11])
    else $error("false carrier latch not cleared");

  det_low_a: assert property ( // [R6]
    !det_qual |=> !summary[10])
    else $error("signal detect drop not latched low");

  det_hold_a: assert property ( // [R6]
    !summary[10] && !sum_rd |=> !summary[10])
    else $error("signal detect rose without a summary read");

  lock_drop_a: assert property ( // [R7]
    !descrambler_lock |=> !summary[9])
    else $error("descrambler lock drop not latched low");

  lock_low_a: assert property ( // [R7]
    !summary[9] && !sum_rd |=> !summary[9])
    else $error("descrambler lock rose without a summary read");

  page_mirror_a: assert property ( // [R8]
    nrst |=> summary[8] == $past(page_received_flag))
    else $error("page received bit does not mirror its flag");

  intp_mirror_a: assert property ( // [R9]
    nrst |=> summary[7] == $past(interrupt_pending))
    else $error("interrupt pending not shown");

  rfault_hold_a: assert property ( // [R10]
    nrst && remote_fault_event ##1 !basic_mode_status_rd [*3] |-> summary[6])
    else $error("remote fault not held until status read");

  rfault_clr_a: assert property ( // [R10]
    basic_mode_status_rd && !remote_fault_event |=> !summary[6])
    else $error("remote fault not cleared by status read");

  jab_mirror_a: assert property ( // [R11]
    nrst |=> summary[5] == $past(jabber_detect_flag))
    else $error("jabber bit does not mirror its flag");

  aneg_mirror_a: assert property ( // [R12]
    nrst && $rose(autoneg_complete) |=> summary[4])
    else $error("autoneg complete not shown");

  reset_zero_a: assert property ( // [R13]
    disable iff (1'b0) $past(nrst) == 1'b0 |-> summary == pss_pkg::SUMMARY_RESET)
    else $error("summary not zero after reset");

  read_keeps_a: assert property ( // [R13]
    sum_rd && !rx_error_count_rd && !false_carrier_count_rd && !basic_mode_status_rd
    |=> high_q == ($past(high_q) | $past({remote_fault_event, false_carrier_event, rx_error_event})))
    else $error("summary read changed a sticky bit");

  // a mask write in the event cycle may legally drop the enable
  irq_level_a: assert property (
    nrst && irq_bus.evt[0] && irq_bus.mask[0] && !irq_bus.wr_mask |=> irq)
    else $error("unmasked event did not raise interrupt");

  stat_w1c_a: assert property (
    irq_bus.wr_status && irq_bus.wdata[0] && !irq_bus.evt[0] |=> !irq_bus.status[0])
    else $error("status bit not cleared by a written one");

  sum_read_c: cover property (sum_rd ##1 hrdata[13]);
  irq_rise_c: cover property ($rose(irq));
  det_loss_c: cover property (det_prev && !det_qual ##1 !summary[10]);
  stat_clear_c: cover property (w_stat && irq_bus.evt != 5'h00);
endmodule : pss_summary
`default_nettype wire

// [bench/pss_summary_tb.sv]
// self-checking bench for the phy status summary block
// assumes the block is the only ahb-lite slave, with hready tied back to hreadyout
`timescale 1ns/1ps
`default_nettype none
module pss_summary_tb;
  logic core_clk;
  logic nrst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic irq;
  // levels: 0 auto 1 force 2 swap 3 pol 4 sd 5 lock 6 page 7 intp 8 jab 9 aneg
  logic [9:0] lv;
  // pulses: 0 rxev 1 rxrd 2 fcev 3 fcrd 4 rfev 5 bmrd
  logic [5:0] pu;
  integer seed = 32'ha34d235f;
  logic [31:0] r;
  logic go;
  int miscompares;
  int check_count;
  logic [15:0] m_sum;
  logic [4:0] m_st;
  logic [4:0] m_mask;
  logic m_ctrl;
  logic wp;
  logic [11:0] wa;
  logic [31:0] exp_rd;
  logic tk;
  logic rs;
  logic dq;
  logic dqp;
  logic lkp;
  logic [4:0] wc;
  logic [11:0] tab [8] = '{12'h010, 12'h010, 12'h020, 12'h024, 12'h028, 12'h000, 12'h0fc, 12'h010};

  assign hready = hreadyout;

  pss_summary dut (.core_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hrdata, .hresp, .crossover_auto_enable(lv[0]), .crossover_force(lv[1]), .crossover_swapped(lv[2]),
    .rx_error_event(pu[0]), .rx_error_count_rd(pu[1]), .tenbase_polarity_inverted(lv[3]),
    .false_carrier_event(pu[2]), .false_carrier_count_rd(pu[3]), .signal_detect_raw(lv[4]),
    .descrambler_lock(lv[5]), .page_received_flag(lv[6]), .interrupt_pending(lv[7]),
    .remote_fault_event(pu[4]), .basic_mode_status_rd(pu[5]), .jabber_detect_flag(lv[8]),
    .autoneg_complete(lv[9]), .irq);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////
  // checking helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_sum(input logic [31:0] e, input logic [31:0] g);
    chk("sum_top", 32'(e[31:15]), 32'(g[31:15]));
    chk("sum_xover", 32'(e[14]), 32'(g[14]));
    chk("sum_rxerr", 32'(e[13]), 32'(g[13]));
    chk("sum_pol", 32'(e[12]), 32'(g[12]));
    chk("sum_fcar", 32'(e[11]), 32'(g[11]));
    chk("sum_sd", 32'(e[10]), 32'(g[10]));
    chk("sum_lock", 32'(e[9]), 32'(g[9]));
    chk("sum_page", 32'(e[8]), 32'(g[8]));
    chk("sum_intp", 32'(e[7]), 32'(g[7]));
    chk("sum_rfault", 32'(e[6]), 32'(g[6]));
    chk("sum_jab", 32'(e[5]), 32'(g[5]));
    chk("sum_aneg", 32'(e[4]), 32'(g[4]));
    chk("sum_low", 32'(e[3:0]), 32'(g[3:0]));
  endtask : chk_sum

  // status bits 4:3 are the lock and detect falling edges, found against the previous cycle's level
  task automatic check(input logic [11:0] a, input logic [31:0] rd);
    if (a == pss_pkg::SUMMARY_OFS) chk_sum(exp_rd, rd);
    else chk($sformatf("reg_%h", a), exp_rd, rd);
  endtask : check

  // one single ahb-lite transfer; waits on hready, never assumes a latency
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    int n = 0;
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
    // a wait that ran out shows here as a mismatch
    chk("hready_addr", 32'h1, 32'(hready));
    htrans <= 2'b00;
    hwdata <= wd;
    n = 0;
    do begin @(posedge core_clk); n++; end while (hready !== 1'b1 && n < 50);
    chk("hready_data", 32'h1, 32'(hready));
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask : bus

  task automatic run(input int n);
    logic [31:0] o;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [11:0] a;
    for (int i = 0; i < n; i++) begin
      o = $random(seed);
      wd = $random(seed);
      a = tab[o[2:0]];
      bus(a, o[3], wd, rd);
      if (!o[3]) check(a, rd);
      repeat (o[5:4]) @(posedge core_clk);
    end
  endtask : run

  task tally_and_finish;
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  //////////////////////////////////////////////////////////////////////
  // source stimulus: levels wander slowly, pulses fire one cycle in eight
  always @(posedge core_clk) begin
    if (go) begin
      r = $random(seed);
      if (r[31:29] == 3'h0) lv <= r[9:0];
      pu <= r[15:10] & r[21:16] & r[27:22];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // reference: register values as they stand before each edge
  function automatic logic [31:0] rd_val(input logic [11:0] a);
    case (a)
      pss_pkg::SUMMARY_OFS: return {16'h0000, m_sum};
      pss_pkg::IRQ_STAT_OFS: return {27'h0, m_st};
      pss_pkg::IRQ_MASK_OFS: return {27'h0, m_mask};
      pss_pkg::CTRL_OFS: return {31'h0, m_ctrl};
      default: return 32'h0;
    endcase
  endfunction : rd_val

  always @(posedge core_clk) begin
    if (go) chk("irq", {31'h0, |(m_st & m_mask)}, {31'h0, irq});
    if (!nrst) begin
      m_sum <= pss_pkg::SUMMARY_RESET;
      m_st <= 5'h00;
      m_mask <= 5'h00;
      m_ctrl <= 1'b0;
      wp <= 1'b0;
      dqp <= 1'b0;
      lkp <= 1'b0;
    end else begin
      tk = hsel & htrans[1] & hready;
      rs = tk & ~hwrite & (haddr[11:0] == pss_pkg::SUMMARY_OFS);
      if (tk & ~hwrite) exp_rd <= rd_val(haddr[11:0]);
      wp <= tk & hwrite;
      wa <= haddr[11:0];
      dq = lv[4] & (m_ctrl ? lv[5] : 1'b1);
      // latch-low bits re-arm to the live level on a summary read
      m_sum <= {1'b0, lv[1] | (lv[0] & lv[2]), pu[0] | (m_sum[13] & ~pu[1]), lv[3], pu[2] | (m_sum[11] & ~pu[3]),
        (rs | m_sum[10]) & dq, (rs | m_sum[9]) & lv[5], lv[6], lv[7], pu[4] | (m_sum[6] & ~pu[5]), lv[8], lv[9],
        4'h0};
      wc = (wp && wa == pss_pkg::IRQ_STAT_OFS) ? hwdata[4:0] : 5'h00;
      m_st <= (m_st & ~wc) | {lkp & ~lv[5], dqp & ~dq, pu[4], pu[2], pu[0]};
      dqp <= dq;
      lkp <= lv[5];
      if (wp && wa == pss_pkg::IRQ_MASK_OFS) m_mask <= hwdata[4:0];
      if (wp && wa == pss_pkg::CTRL_OFS) m_ctrl <= hwdata[0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    {nrst, hsel, haddr, htrans, hwrite, hsize, hwdata, lv, pu, go} = '0;
    miscompares = 0;
    check_count = 0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      bus(tab[i], 1'b0, 32'h0, rd);
      chk("reset_val", 32'h0, rd);
    end
    go <= 1'b1;
    // writes to the summary must not land
    bus(pss_pkg::SUMMARY_OFS, 1'b1, 32'hffffffff, rd);
    bus(pss_pkg::SUMMARY_OFS, 1'b0, 32'h0, rd);
    check(pss_pkg::SUMMARY_OFS, rd);
    // a write then a read of the same register sees the new value
    bus(pss_pkg::CTRL_OFS, 1'b1, 32'h1, rd);
    bus(pss_pkg::CTRL_OFS, 1'b0, 32'h0, rd);
    check(pss_pkg::CTRL_OFS, rd);
    run(250);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    run(250);
    tally_and_finish();
  end

  initial begin
    #(20000 * 100);
    miscompares++;
    tally_and_finish();
  end
endmodule : pss_summary_tb
`default_nettype wire
